// [core/flash_lock_host.sv]
// Host controller that drives block lock sequences onto a flash bus
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Rising protect pin: block takes pin-high state
// R2 - Falling protect pin: lock-down blocks relock
// R3 - Lock: setup code, then lock confirm, same address
// R4 - Unlock: setup code, then unlock confirm
// R5 - After lock command, reads return status
// R6 - Lock change completes within one command cycle
// R7 - Bad confirm sets both error flags
// R8 - Identifier read at base plus two
// R9 - Host verifies lock bits after each change
// R10 - Error flags stay until clear status
// R11 - Clear status after error, then read array
// R12 - Status ready bit shows engine idle
// R13 - Unlocked blocks allow erase and program
// R14 - Reset leaves every block locked, not down
// R15 - Lock-down on unlocked block also locks
// R16 - Lock-down ignores commands while pin low
// R17 - Device keeps per-block lock state bits
// R18 - Locked blocks refuse erase and program
module flash_lock_host
  import flash_lock_pkg::*;
#(
  parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output fl_pins_t               fl_pins,
  input  wire logic [DATA_W-1:0] fl_dq_i,
  output logic                   wp_n
);

  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_CONFIRM, S_STAT, S_CLR, S_ID, S_IDRD, S_ARRAY, S_RSTW, S_RSTR
  } seq_t;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_STAT) || (a == REG_WP) ||
             (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK) || (a == REG_RDATA);
  endfunction : mapped

  seq_t              st_q, st_d;
  fl_req_t           req;
  logic              req_valid;
  logic              done;
  logic [DATA_W-1:0] rdata;
  logic [2:0]        op_q, op_d;
  logic [7:0]        code_q, code_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              wp_q, wp_d;
  logic [2:0]        mask_q, mask_d;
  logic [2:0]        irq_q, irq_d;
  logic [2:0]        ev;
  logic              err_q, err_d;
  logic              vfail_q, vfail_d;
  logic [7:0]        sbyte_q, sbyte_d;
  logic [DATA_W-1:0] idw_q, idw_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              sr_err;
  logic              id_ok;
  logic              wr_acc;
  logic              rd_acc;
  logic [7:0]        reg_a;

  flash_bus_cycle u_cycle (
    .clk       (clk),
    .resetn    (resetn),
    .req_valid (req_valid),
    .req       (req),
    .done      (done),
    .rdata     (rdata),
    .pins      (fl_pins),
    .dq_i      (fl_dq_i)
  );

  assign sr_err = rdata[SR_SEQ_ERR_BIT] && rdata[SR_PROG_ERR_BIT];
  assign reg_a  = {paddr[7:2], 2'b00};
  assign wr_acc = psel && penable && pwrite && mapped(reg_a);
  assign rd_acc = psel && penable && !pwrite && mapped(reg_a);

  // Expected identifier bits for the operation just performed
  always_comb begin
    case (op_q)
      OP_LOCK:     id_ok = rdata[ID_LOCK_BIT];
      OP_LOCKDOWN: id_ok = rdata[ID_LOCK_BIT] && rdata[ID_LOCKDOWN_BIT];
      OP_UNLOCK:   id_ok = !rdata[ID_LOCK_BIT];
      default:     id_ok = 1'b1;
    endcase
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_comb begin
    st_d      = st_q;
    ev        = 3'h0;
    req_valid = (st_q != S_IDLE);
    req       = '{wr: 1'b1, addr: addr_q, data: '0};
    case (st_q)
      S_IDLE: begin
        if (wr_acc && reg_a == REG_CTRL && pwdata[2:0] != OP_NONE) begin
          case (pwdata[2:0])
            OP_RD_STAT:  st_d = S_RSTW;
            OP_CLR_STAT: st_d = S_CLR;
            OP_RD_LOCK:  st_d = S_ID;
            default:     st_d = S_SETUP;
          endcase
        end
      end
      S_SETUP: begin
        req.data = {8'h00, CMD_LOCK_SETUP};                          // R3 R4
        if (done) st_d = S_CONFIRM;
      end
      S_CONFIRM: begin
        case (op_q)
          OP_LOCK:     req.data = {8'h00, CMD_LOCK};                 // R3
          OP_LOCKDOWN: req.data = {8'h00, CMD_LOCKDOWN};             // R3
          OP_UNLOCK:   req.data = {8'h00, CMD_UNLOCK};               // R4
          default:     req.data = {8'h00, code_q};
        endcase
        // The change completes inside one command cycle, so no busy poll
        if (done) st_d = S_STAT;                                     // R6
      end
      S_STAT: begin
        req.wr = 1'b0;                                               // R5
        if (done) begin
          ev[IRQ_ERR] = sr_err;
          st_d        = sr_err ? S_CLR : S_ID;                       // R11
        end
      end
      S_CLR: begin
        req.data = {8'h00, CMD_CLEAR_STATUS};                        // R11
        if (done) begin
          st_d = (op_q == OP_CLR_STAT) ? S_IDLE : S_ARRAY;
          ev[IRQ_DONE] = (op_q == OP_CLR_STAT);
        end
      end
      S_ID: begin
        req.data = {8'h00, CMD_READ_ID};                             // R8
        if (done) st_d = S_IDRD;
      end
      S_IDRD: begin
        req.wr   = 1'b0;
        req.addr = addr_q + LOCK_WORD_OFFSET;                        // R8
        if (done) begin
          ev[IRQ_VFAIL] = !id_ok;                                    // R9
          st_d          = S_ARRAY;
        end
      end
      S_ARRAY: begin
        req.data = {8'h00, CMD_READ_ARRAY};                          // R11
        if (done) begin
          ev[IRQ_DONE] = 1'b1;
          st_d         = S_IDLE;
        end
      end
      S_RSTW: begin
        req.data = {8'h00, CMD_READ_STATUS};                         // R12
        if (done) st_d = S_RSTR;
      end
      S_RSTR: begin
        req.wr = 1'b0;
        // Keep reading status until the engine reports ready
        if (done && rdata[SR_READY_BIT]) begin                       // R12
          ev[IRQ_DONE] = 1'b1;
          ev[IRQ_ERR]  = sr_err;
          st_d         = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) st_q <= S_IDLE;
    else         st_q <= st_d;
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_comb begin
    op_d     = op_q;
    code_d   = code_q;
    addr_d   = addr_q;
    wp_d     = wp_q;
    mask_d   = mask_q;
    err_d    = err_q;
    vfail_d  = vfail_q;
    sbyte_d  = sbyte_q;
    idw_d    = idw_q;
    prdata_d = prdata_q;
    irq_d    = irq_q;
    if (st_q == S_IDLE && wr_acc && reg_a == REG_CTRL) begin
      op_d   = pwdata[2:0];
      code_d = pwdata[15:8];
    end
    if (st_q == S_IDLE && wr_acc && reg_a == REG_ADDR) addr_d = pwdata[ADDR_W-1:0];
    if (wr_acc && reg_a == REG_WP)       wp_d   = pwdata[0];
    if (wr_acc && reg_a == REG_IRQ_MASK) mask_d = pwdata[2:0];
    if (done && (st_q == S_STAT || st_q == S_RSTR)) sbyte_d = rdata[7:0];
    if (done && st_q == S_IDRD) idw_d = rdata;
    if (st_q == S_IDLE && st_d != S_IDLE) begin
      err_d   = 1'b0;
      vfail_d = 1'b0;
    end
    if (ev[IRQ_ERR])   err_d   = 1'b1;
    if (ev[IRQ_VFAIL]) vfail_d = 1'b1;
    if (psel && !penable) begin
      case ({paddr[7:2], 2'b00})
        REG_CTRL:     prdata_d = {16'h0000, code_q, 5'h00, op_q};
        REG_ADDR:     prdata_d = {{(32 - ADDR_W){1'b0}}, addr_q};
        REG_STAT:     prdata_d = {29'h0, vfail_q, err_q, st_q != S_IDLE};
        REG_WP:       prdata_d = {31'h0, wp_q};
        REG_IRQ_STAT: prdata_d = {29'h0, irq_q};
        REG_IRQ_MASK: prdata_d = {29'h0, mask_q};
        REG_RDATA:    prdata_d = {idw_q, 8'h00, sbyte_q};
        default:      prdata_d = 32'h0000_0000;
      endcase
    end
    // A read clears only the bits it reported; an event after its setup cycle survives
    if (rd_acc && reg_a == REG_IRQ_STAT) irq_d = irq_q & ~prdata_q[2:0];
    irq_d = irq_d | ev;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_q     <= OP_NONE;
      code_q   <= 8'h00;
      addr_q   <= '0;
      wp_q     <= WP_RESET;
      mask_q   <= MASK_RESET;
      err_q    <= 1'b0;
      vfail_q  <= 1'b0;
      sbyte_q  <= 8'h00;
      idw_q    <= '0;
      prdata_q <= 32'h0000_0000;
      irq_q    <= 3'h0;
    end else begin
      op_q     <= op_d;
      code_q   <= code_d;
      addr_q   <= addr_d;
      wp_q     <= wp_d;
      mask_q   <= mask_d;
      err_q    <= err_d;
      vfail_q  <= vfail_d;
      sbyte_q  <= sbyte_d;
      idw_q    <= idw_d;
      prdata_q <= prdata_d;
      irq_q    <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(reg_a);
  assign irq     = |(irq_q & mask_q);
  assign wp_n    = wp_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [DATA_W-1:0] last_wdata_q;
  logic [ADDR_W-1:0] last_waddr_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_wdata_q <= '0;
      last_waddr_q <= '0;
    end else if (done && req.wr) begin
      last_wdata_q <= req.data;
      last_waddr_q <= req.addr;
    end
  end

  property p_confirm_after_setup;
    @(posedge clk) disable iff (!resetn)
      (done && st_q == S_CONFIRM) |->
        (last_wdata_q[7:0] == CMD_LOCK_SETUP) && (req.addr == last_waddr_q);
  endproperty
  a_confirm_after_setup: assert property (p_confirm_after_setup) // R3
    else $error("confirm not preceded by setup at same address");

  property p_unlock_code;
    @(posedge clk) disable iff (!resetn)
      (st_q == S_SETUP && done && op_q == OP_UNLOCK) ##1 (st_q == S_CONFIRM)[*1]
        |-> req.data[7:0] == CMD_UNLOCK;
  endproperty
  a_unlock_code: assert property (p_unlock_code) // R4
    else $error("unlock confirm carries wrong code");

  property p_id_read;
    @(posedge clk) disable iff (!resetn)
      (done && st_q == S_IDRD) |->
        !req.wr && last_wdata_q[7:0] == CMD_READ_ID && req.addr == addr_q + LOCK_WORD_OFFSET;
  endproperty
  a_id_read: assert property (p_id_read) // R8
    else $error("lock word read not at base plus two after id command");

  property p_unlock_verify;
    @(posedge clk) disable iff (!resetn)
      (done && st_q == S_IDRD && op_q == OP_UNLOCK && rdata[ID_LOCK_BIT])
        |=> irq_q[IRQ_VFAIL] && vfail_q && st_q == S_ARRAY;
  endproperty
  a_unlock_verify: assert property (p_unlock_verify) // R9
    else $error("failed unlock not reported");

  property p_clear_after_err;
    @(posedge clk) disable iff (!resetn)
      (done && st_q == S_STAT && sr_err) |=> st_q == S_CLR ##1 req.data[7:0] == CMD_CLEAR_STATUS;
  endproperty
  a_clear_after_err: assert property (p_clear_after_err) // R11
    else $error("error not followed by clear status");

  property p_array_last;
    @(posedge clk) disable iff (!resetn)
      ($fell(req_valid) && $past(op_q) != OP_RD_STAT && $past(op_q) != OP_CLR_STAT)
        |-> last_wdata_q[7:0] == CMD_READ_ARRAY;
  endproperty
  a_array_last: assert property (p_array_last) // R11
    else $error("sequence ended without read array");

  property p_status_poll;
    @(posedge clk) disable iff (!resetn)
      (done && st_q == S_RSTR && !rdata[SR_READY_BIT]) |=> (st_q == S_RSTR && req_valid);
  endproperty
  a_status_poll: assert property (p_status_poll) // R12
    else $error("busy status not polled again");

  c_lock_done: cover property (@(posedge clk) disable iff (!resetn)
    st_q == S_ARRAY && done && op_q == OP_LOCK);
  c_error_path: cover property (@(posedge clk) disable iff (!resetn)
    st_q == S_CLR && done && op_q == OP_RAW);
  c_poll_busy: cover property (@(posedge clk) disable iff (!resetn)
    st_q == S_RSTR && done && !rdata[SR_READY_BIT]);

endmodule : flash_lock_host
`default_nettype wire

// [pkg/flash_lock_pkg.sv]
// Shared constants, codes and carrier types of the flash lock controller
package flash_lock_pkg;

  // ****************************************************************
  // Flash bus shape
  // ****************************************************************
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ****************************************************************
  // Flash command codes
  // ****************************************************************
  localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
  localparam logic [7:0] CMD_LOCK        = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN    = 8'h2F;
  localparam logic [7:0] CMD_UNLOCK      = 8'hD0;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [ADDR_W-1:0] LOCK_WORD_OFFSET = 22'h00_0002;

  // Status and identifier bit positions
  localparam int SR_READY_BIT    = 7;
  localparam int SR_SEQ_ERR_BIT  = 5;
  localparam int SR_PROG_ERR_BIT = 4;
  localparam int ID_LOCK_BIT     = 0;
  localparam int ID_LOCKDOWN_BIT = 1;

  // ****************************************************************
  // Flash bus timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_SETUP_NS    = 20;
  localparam int T_PULSE_NS    = 60;
  localparam int T_ACCESS_NS   = 100;
  localparam int T_HOLD_NS     = 20;
  localparam int SYNC_CYC      = 3;
  localparam logic [3:0] SETUP_CYC =
    4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_CYC =
    4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_CYC =
    4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);
  localparam logic [3:0] HOLD_CYC =
    4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Software registers (byte offsets) and fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_STAT     = 8'h08;
  localparam logic [7:0] REG_WP       = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_RDATA    = 8'h18;

  localparam logic [2:0] OP_NONE     = 3'h0;
  localparam logic [2:0] OP_LOCK     = 3'h1;
  localparam logic [2:0] OP_LOCKDOWN = 3'h2;
  localparam logic [2:0] OP_UNLOCK   = 3'h3;
  localparam logic [2:0] OP_RD_STAT  = 3'h4;
  localparam logic [2:0] OP_CLR_STAT = 3'h5;
  localparam logic [2:0] OP_RD_LOCK  = 3'h6;
  localparam logic [2:0] OP_RAW      = 3'h7;

  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_VFAIL = 2;

  localparam logic        WP_RESET   = 1'b0;
  localparam logic [2:0]  MASK_RESET = 3'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fl_req_t;

  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
  } fl_pins_t;

endpackage : flash_lock_pkg

// [core/flash_bus_cycle.sv]
// One asynchronous flash bus write or read cycle, timed from the system clock
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
  import flash_lock_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              req_valid,
  input  wire fl_req_t           req,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output fl_pins_t               pins,
  input  wire logic [DATA_W-1:0] dq_i
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_SETTLE, E_HOLD, E_DONE} eng_t;

  eng_t              st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic              wr_q, wr_d;
  fl_pins_t          pins_q, pins_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;

  // ****************************************************************
  // Data pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    pins_d  = pins_q;
    rdata_d = rdata_q;
    case (st_q)
      E_IDLE: begin
        if (req_valid) begin
          wr_d         = req.wr;
          pins_d.ce_n  = 1'b0;
          pins_d.addr  = req.addr;
          pins_d.dq_o  = req.data;
          pins_d.dq_oe = req.wr;
          cnt_d        = SETUP_CYC - 4'd1;
          st_d         = E_SETUP;
        end
      end
      E_SETUP: begin
        if (cnt_q == 4'd0) begin
          pins_d.we_n = !wr_q;
          pins_d.oe_n = wr_q;
          cnt_d       = wr_q ? PULSE_CYC - 4'd1 : READ_CYC - 4'd1;
          st_d        = E_STROBE;
        end else begin
          cnt_d = cnt_q - 4'd1;
        end
      end
      E_STROBE: begin
        if (cnt_q != 4'd0) begin
          cnt_d = cnt_q - 4'd1;
        end else if (wr_q) begin
          // Data is latched by the device on the rising write strobe
          pins_d.we_n = 1'b1;
          cnt_d       = HOLD_CYC - 4'd1;
          st_d        = E_HOLD;
        end else begin
          st_d = E_SETTLE;
        end
      end
      E_SETTLE: begin
        // Only a word seen twice in a row is trusted
        if (s2_q == s3_q) begin
          rdata_d     = s3_q;
          pins_d.oe_n = 1'b1;
          cnt_d       = HOLD_CYC - 4'd1;
          st_d        = E_HOLD;
        end
      end
      E_HOLD: begin
        if (cnt_q == 4'd0) begin
          pins_d.ce_n  = 1'b1;
          pins_d.dq_oe = 1'b0;
          st_d         = E_DONE;
        end else begin
          cnt_d = cnt_q - 4'd1;
        end
      end
      E_DONE: st_d = E_IDLE;
      default: st_d = E_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= E_IDLE;
      cnt_q   <= 4'd0;
      wr_q    <= 1'b0;
      pins_q  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
      rdata_q <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      pins_q  <= pins_d;
      rdata_q <= rdata_d;
    end
  end

  assign done  = (st_q == E_DONE);
  assign rdata = rdata_q;
  assign pins  = pins_q;

endmodule : flash_bus_cycle
`default_nettype wire

// [test/flash_dev_model.sv]
// Behavioural flash device: block lock bits, status and identifier reads
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_lock_pkg::*;
#(
  parameter int         BLK_SH = 15,
  parameter logic [7:0] CLR    = 8'h50
) (
  input  wire fl_pins_t          pins,
  input  wire logic              wp_n,
  output logic [DATA_W-1:0]      dq
);
  logic [3:0]        lk, ld, du;
  logic              setup, seq_e, prg_e, busy;
  logic [1:0]        mode;
  logic [DATA_W-1:0] rv, last;
  logic [7:0]        c;
  int                b;
  // ************************************************
  // Lock state, kept per block
  // ************************************************
  initial begin
    lk = 4'hF;
    ld = 4'h0;
    du = 4'h0;
    {setup, seq_e, prg_e, busy, mode, last} = '0;
  end
  always @(posedge wp_n) for (int i = 0; i < 4; i++) if (ld[i]) lk[i] = !du[i];
  always @(negedge wp_n) begin
    for (int i = 0; i < 4; i++) if (ld[i]) begin
      du[i] = !lk[i];
      lk[i] = 1'b1;
    end
  end
  // ************************************************
  // Command decode on the write strobe's rising edge
  // ************************************************
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    b = int'(pins.addr[BLK_SH+:2]);
    c = pins.dq_o[7:0];
    if (setup) begin
      setup = 1'b0;
      mode  = 2'h1;
      case (c)
        CMD_LOCK:     lk[b] = 1'b1;
        CMD_LOCKDOWN: {ld[b], lk[b]} = 2'h3;
        CMD_UNLOCK:   if (!(ld[b] && !wp_n)) lk[b] = 1'b0;
        default:      {seq_e, prg_e} = 2'h3;
      endcase
    end else begin
      case (c)
        CMD_LOCK_SETUP:  {setup, mode} = 3'h5;
        // Engine shows busy for one status read so the host's poll is exercised
        CMD_READ_STATUS: {busy, mode} = 3'h5;
        CMD_READ_ID:     mode = 2'h2;
        CMD_READ_ARRAY:  mode = 2'h0;
        CLR:             {seq_e, prg_e} = 2'h0;
        default:         ;
      endcase
    end
  end
  always @* begin
    case (mode)
      2'h1:    rv = {8'h00, !busy, 1'b0, seq_e, prg_e, 4'h0};
      2'h2:    rv = (pins.addr[BLK_SH-1:0] == BLK_SH'(2)) ?
                 {14'h0, ld[pins.addr[BLK_SH+:2]], lk[pins.addr[BLK_SH+:2]]} : '0;
      default: rv = pins.addr[15:0];
    endcase
  end
  // Released bus shows the inverse of the last word so stale data never matches
  always @(posedge pins.oe_n) begin
    last = rv;
    if (mode == 2'h1) busy = 1'b0;
  end
  assign dq = (!pins.ce_n && !pins.oe_n) ? rv : ~last;
endmodule : flash_dev_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench of the flash lock host over APB
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_lock_pkg::*;
  localparam logic [21:0] B1 = 22'h00_8000;
  localparam logic [21:0] B2 = 22'h01_0000;
  logic              clk = 1'b0;
  logic              resetn, psel, penable, pwrite;
  logic [31:0]       paddr, pwdata, prdata, ev, r;
  logic              pready, pslverr, irq, wp_n, seen, err_seen;
  logic [2:0]        mask;
  fl_pins_t          fl_pins;
  logic [DATA_W-1:0] dq;
  int                n_errors = 0;
  int                total_checks = 0;
  always #10 clk = ~clk;
  flash_lock_host dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .fl_pins(fl_pins), .fl_dq_i(dq), .wp_n(wp_n));
  flash_dev_model mdl (.pins(fl_pins), .wp_n(wp_n), .dq(dq));
  // ************************************************
  // Bus and check tasks
  // ************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // Back to back: psel stays up, so callers must release it when done
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err_seen = pslverr;
    seen |= irq;
  endtask : apb
  task automatic op(input logic [2:0] o, input logic [21:0] a, input logic [7:0] c = 8'h00);
    int n;
    apb(1'b1, REG_ADDR, {10'h000, a});
    apb(1'b1, REG_CTRL, {16'h0000, c, 5'h00, o});
    ev = '0;
    seen = 1'b0;
    n = 0;
    do begin
      apb(1'b0, REG_IRQ_STAT, '0);
      ev |= r;
      n++;
    end while (!ev[IRQ_DONE] && n < 400);
    chk({31'h0, ev[IRQ_DONE]}, 32'h0000_0001);
    chk({31'h0, seen}, {31'h0, |(ev[2:0] & mask)});
  endtask : op
  task automatic lw(input logic [21:0] a, input logic [1:0] e);
    op(OP_RD_LOCK, a);
    apb(1'b0, REG_RDATA, '0);
    chk({30'h0, r[17:16]}, {30'h0, e});
  endtask : lw
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // ************************************************
  // Tests
  // ************************************************
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, mask, seen} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, REG_IRQ_MASK, '0);
    chk(r & 32'h0000_0007, 32'h0000_0000);
    chk({31'h0, wp_n}, 32'h0000_0000);
    lw(B1, 2'h1);
    $display("test reset done");
    op(OP_UNLOCK, B1);
    chk(ev, 32'h0000_0001);
    lw(B1, 2'h0);
    lw(B2, 2'h1);
    op(OP_LOCK, B1);
    lw(B1, 2'h1);
    $display("test lock done");
    op(OP_UNLOCK, B2);
    op(OP_LOCKDOWN, B2);
    lw(B2, 2'h3);
    mask = 3'h4;
    apb(1'b1, REG_IRQ_MASK, 32'h0000_0004);
    op(OP_UNLOCK, B2);
    chk(ev, 32'h0000_0005);
    apb(1'b0, REG_IRQ_STAT, '0);
    chk(r, 32'h0000_0000);
    $display("test lockdown done");
    apb(1'b1, REG_WP, 32'h0000_0001);
    lw(B2, 2'h3);
    chk({31'h0, wp_n}, 32'h0000_0001);
    op(OP_UNLOCK, B2);
    chk(ev, 32'h0000_0001);
    lw(B2, 2'h2);
    apb(1'b1, REG_WP, 32'h0000_0000);
    lw(B2, 2'h3);
    apb(1'b1, REG_WP, 32'h0000_0001);
    lw(B2, 2'h2);
    apb(1'b1, REG_WP, 32'h0000_0000);
    $display("test pin edges done");
    op(OP_RAW, B1, 8'hAA);
    chk(ev, 32'h0000_0003);
    apb(1'b0, REG_RDATA, '0);
    chk(r & 32'h0000_00FF, 32'h0000_00B0);
    lw(B1, 2'h1);
    op(OP_RD_STAT, B1);
    apb(1'b0, REG_RDATA, '0);
    chk(r & 32'h0000_00FF, 32'h0000_0080);
    op(OP_CLR_STAT, B1);
    chk(ev, 32'h0000_0001);
    apb(1'b0, 8'hFC, '0);
    chk({31'h0, err_seen}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    $display("test errors done");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
